// [design/sdmb_bank.v]
// Purpose: One bank state machine with its own timer
// Assumes: Commands arrive already decoded and gated by the top
// Notes:   Auto precharge is started by the bank itself when told
`include "sdmb_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module sdmb_bank #(
    parameter TW = 8                     // Timer width
) (
    input  wire          i_clk,          // System clock
    input  wire          i_reset,        // Sync reset
    input  wire          i_ce,           // Clock enable, freezes state
    input  wire          i_force_idle,   // Power-down or refresh exit
    input  wire          i_act,          // ACTIVE to this bank
    input  wire          i_rd,           // READ to this bank
    input  wire          i_wr,           // WRITE to this bank
    input  wire          i_ap,           // Auto precharge with rd/wr
    input  wire          i_pre,          // PRECHARGE to this bank
    input  wire          i_stop,         // Burst ended (other bank or terminate)
    input  wire          i_burst_done,   // Own burst ran to its end
    output reg  [2:0]    o_state,        // Bank state
    output reg           o_ap            // Auto precharge pending
);

    reg [TW-1:0] timer_q;

    // Phase loads held at timer width; plain Verilog has no size cast
    localparam [TW-1:0] ACT_LOAD = `SDMB_ACT_COL_CYC - 1;
    localparam [TW-1:0] PRE_LOAD = `SDMB_PRECHARGE_CYC - 1;
    localparam [TW-1:0] WRR_LOAD = `SDMB_WR_RECOVER_CYC - 1;

    // Bank state machine; timer counts down phase lengths
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_state <= `SDMB_ST_IDLE;
            o_ap    <= 1'b0;
            timer_q <= {TW{1'b0}};
        end else if (i_ce) begin
            if (timer_q != {TW{1'b0}})
                timer_q <= timer_q - 1'b1;
            if (i_force_idle) begin
                o_state <= `SDMB_ST_IDLE;
                o_ap    <= 1'b0;
            end else if (i_rd || i_wr) begin
                o_state <= i_rd ? `SDMB_ST_READ : `SDMB_ST_WRITE;
                o_ap    <= i_ap;
            end else if (i_act) begin
                o_state <= `SDMB_ST_ACTIVATING;
                timer_q <= ACT_LOAD;
            end else if (i_pre && o_state != `SDMB_ST_IDLE) begin
                o_state <= `SDMB_ST_PRECHARGING;
                o_ap    <= 1'b0;
                timer_q <= PRE_LOAD;
            end else begin
                case (o_state)
                    `SDMB_ST_ACTIVATING, `SDMB_ST_PRECHARGING: begin
                        if (timer_q == {TW{1'b0}})
                            o_state <= (o_state == `SDMB_ST_ACTIVATING) ? `SDMB_ST_ACTIVE : `SDMB_ST_IDLE;
                    end
                    `SDMB_ST_READ: begin
                        if (i_stop || i_burst_done) begin
                            // Read with auto precharge precharges on the ending edge
                            o_state <= o_ap ? `SDMB_ST_PRECHARGING : `SDMB_ST_ACTIVE;
                            timer_q <= PRE_LOAD;
                            o_ap    <= 1'b0;
                        end
                    end
                    `SDMB_ST_WRITE: begin
                        if (i_stop || i_burst_done) begin
                            // Write with auto precharge waits out write recovery first
                            o_state <= o_ap ? `SDMB_ST_WR_RECOVER : `SDMB_ST_ACTIVE;
                            timer_q <= WRR_LOAD;
                        end
                    end
                    `SDMB_ST_WR_RECOVER: begin
                        if (timer_q == {TW{1'b0}}) begin
                            o_state <= `SDMB_ST_PRECHARGING;
                            o_ap    <= 1'b0;
                            timer_q <= PRE_LOAD;
                        end
                    end
                    default: o_state <= o_state;
                endcase
            end
        end
    end

endmodule // sdmb_bank
`default_nettype wire

// [design/sdmb_core.v]
// Purpose: Command decode, bank tracking and clock-enable states of a four-bank SDRAM
// Assumes: Pins sampled synchronously on I_CLK; controller keeps its own timing
// Notes:   Tracks state only; data path shown as strobes for the data stream
`include "sdmb_defs.vh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Chip select high: inhibit, operations continue
// - All strobes high: no-operation, continue
// - Decode ACTIVE, READ, WRITE, PRECHARGE
// - Cross-bank rules only with clock enable high twice
// - Idle bank restricts nothing elsewhere
// - Busy bank permits commands to others
// - Bursting bank permits commands to others
// - Burst terminate hits only current burst
// - Interrupted auto precharge burst self-precharges
// - Precharge elsewhere leaves burst running
// - New read takes data one latency later
// - Read interrupt starts precharge on registration
// - Write ends read burst when registered
// - Write interrupt starts read precharge at once
// - Read ends write; last word one earlier
// - Write ends write; last word one earlier
// - Interrupted write precharges after write recovery
// - Auto precharge states end idle after precharge
// - Clock enable low twice holds low-power state
// - Power-down exit leaves banks idle next edge
// - Suspend exit resumes, next command next edge
// - Refresh with falling enable enters self refresh
module sdmb_core #(
    parameter NBANK = 4,                         // Number of banks
    parameter RL    = `SDMB_READ_LATENCY,        // Read latency in clocks
    parameter BL    = `SDMB_BURST_LEN            // Burst length in words
) (
    input  wire                I_CLK,            // System clock
    input  wire                I_RESET,          // Sync reset, active high
    input  wire                I_CE,             // Clock enable of this logic
    input  wire                I_CKE,            // Memory clock enable pin
    input  wire                I_CS_N,           // Chip select, active low
    input  wire                I_RAS_N,          // Row strobe, active low
    input  wire                I_CAS_N,          // Column strobe, active low
    input  wire                I_WE_N,           // Write enable, active low
    input  wire [1:0]          I_BA,             // Bank address
    input  wire                I_AP,             // Auto precharge / all-banks bit
    output reg  [3*NBANK-1:0]  O_BANK_STATE,     // Per-bank state
    output reg  [1:0]          O_PWR_STATE,      // Power state
    output reg                 O_RD_DATA_VALID,  // Read word on output stream
    output reg  [1:0]          O_RD_DATA_BANK,   // Bank driving output stream
    output reg                 O_WR_DATA_TAKE,   // Write word accepted this edge
    output reg                 O_CMD_ACCEPT,     // Command took effect
    output reg                 O_ILLEGAL         // Command refused as illegal
);

    reg          cke_prev_q;
    reg  [7:0]   xsr_cnt_q;
    reg  [1:0]   nop_cnt_q;
    reg  [1:0]   cur_bank_q;
    reg          cur_rd_q;
    reg          burst_on_q;
    reg  [7:0]   burst_cnt_q;
    reg  [RL-1:0] rd_pipe_q;
    reg  [2*RL-1:0] rd_bank_pipe_q;

    // Counter loads at counter width
    localparam [7:0] BURST_LOAD   = BL;
    localparam [7:0] SR_EXIT_LOAD = `SDMB_SR_EXIT_CYC;
    localparam [1:0] SR_MIN_NOPS  = `SDMB_SR_MIN_NOPS;

    wire [2:0]   cmd;
    wire         cmd_live;
    wire         cmd_ok;
    wire         all_idle;
    wire [2:0]   bank_st [0:NBANK-1];
    wire [NBANK-1:0] idle_vec;

    // Inhibit masks strobes; all high decodes to no-operation
    assign cmd = I_CS_N ? `SDMB_CMD_NOP : {I_RAS_N, I_CAS_N, I_WE_N};
    // Commands act only with enable high both edges and exit period over
    assign cmd_live = cke_prev_q && I_CKE && (O_PWR_STATE == `SDMB_PWR_NORMAL) &&
                      (xsr_cnt_q == 8'h00);
    assign all_idle = &idle_vec;
    // Refresh and mode load refused unless all banks idle
    assign cmd_ok = !(((cmd == `SDMB_CMD_REF) || (cmd == `SDMB_CMD_LMR)) && !all_idle);

    // Bank strobes; other banks may take any command their own state supports
    genvar g;
    generate
        for (g = 0; g < NBANK; g = g + 1) begin : g_bank
            localparam [1:0] BANK_ID = g;
            wire sel  = cmd_live && cmd_ok && (I_BA == BANK_ID);
            wire is_rd = sel && (cmd == `SDMB_CMD_RD);
            wire is_wr = sel && (cmd == `SDMB_CMD_WR);
            wire is_pre = cmd_live && (cmd == `SDMB_CMD_PRE) && ((I_BA == BANK_ID) || I_AP);
            // A new burst in another bank ends this bank's burst on its registering edge
            wire other_burst = cmd_live && ((cmd == `SDMB_CMD_RD) || (cmd == `SDMB_CMD_WR)) &&
                               (I_BA != BANK_ID);
            // Terminate only touches the current burst's bank
            wire bst = cmd_live && (cmd == `SDMB_CMD_BST) && burst_on_q &&
                       (cur_bank_q == BANK_ID);
            wire done = burst_on_q && (cur_bank_q == BANK_ID) && (burst_cnt_q == 8'h01);
            wire [2:0] st;
            sdmb_bank u_bank (
                .i_clk        (I_CLK),
                .i_reset      (I_RESET),
                .i_ce         (I_CE),
                .i_force_idle (1'b0),
                .i_act        (sel && (cmd == `SDMB_CMD_ACT)),
                .i_rd         (is_rd),
                .i_wr         (is_wr),
                .i_ap         (I_AP),
                .i_pre        (is_pre),
                .i_stop       (other_burst || bst),
                .i_burst_done (done),
                .o_state      (st),
                .o_ap         ()
            );
            assign bank_st[g]  = st;
            assign idle_vec[g] = (st == `SDMB_ST_IDLE);
        end
    endgenerate

    // Current burst tracking, reset by new bursts or terminate
    always @(posedge I_CLK) begin
        if (I_RESET) begin
            cur_bank_q  <= 2'h0;
            cur_rd_q    <= 1'b0;
            burst_on_q  <= 1'b0;
            burst_cnt_q <= 8'h00;
        end else if (I_CE && O_PWR_STATE != `SDMB_PWR_SUSPEND) begin
            if (cmd_live && ((cmd == `SDMB_CMD_RD) || (cmd == `SDMB_CMD_WR))) begin
                cur_bank_q  <= I_BA;
                cur_rd_q    <= (cmd == `SDMB_CMD_RD);
                burst_on_q  <= 1'b1;
                burst_cnt_q <= BURST_LOAD;
            end else if ((cmd_live && cmd == `SDMB_CMD_BST) || burst_cnt_q == 8'h01) begin
                burst_on_q  <= 1'b0;
                burst_cnt_q <= 8'h00;
            end else if (burst_on_q) begin
                burst_cnt_q <= burst_cnt_q - 8'h01;
            end
        end
    end

    // Power state from present and previous clock enable
    always @(posedge I_CLK) begin
        if (I_RESET) begin
            cke_prev_q  <= 1'b1;
            O_PWR_STATE <= `SDMB_PWR_NORMAL;
            xsr_cnt_q   <= 8'h00;
            nop_cnt_q   <= 2'h0;
        end else if (I_CE) begin
            cke_prev_q <= I_CKE;
            if (xsr_cnt_q != 8'h00)
                xsr_cnt_q <= xsr_cnt_q - 8'h01;
            // Count nops seen during exit; exit period never ends before two
            if (xsr_cnt_q != 8'h00 && cmd == `SDMB_CMD_NOP && nop_cnt_q != 2'h3)
                nop_cnt_q <= nop_cnt_q + 2'h1;
            if (xsr_cnt_q == 8'h01 && nop_cnt_q < SR_MIN_NOPS)
                xsr_cnt_q <= 8'h01;
            case (O_PWR_STATE)
                `SDMB_PWR_NORMAL: begin
                    if (cke_prev_q && !I_CKE) begin
                        if (all_idle && cmd == `SDMB_CMD_REF)
                            O_PWR_STATE <= `SDMB_PWR_SELFREF;
                        else if (all_idle && cmd == `SDMB_CMD_NOP)
                            O_PWR_STATE <= `SDMB_PWR_POWERDOWN;
                        else if (burst_on_q)
                            O_PWR_STATE <= `SDMB_PWR_SUSPEND;
                    end
                end
                `SDMB_PWR_POWERDOWN: begin
                    // Low twice holds; rise with nop exits, banks idle next edge
                    if (I_CKE && cmd == `SDMB_CMD_NOP)
                        O_PWR_STATE <= `SDMB_PWR_NORMAL;
                end
                `SDMB_PWR_SELFREF: begin
                    // All other inputs ignored here
                    if (I_CKE && cmd == `SDMB_CMD_NOP) begin
                        O_PWR_STATE <= `SDMB_PWR_NORMAL;
                        xsr_cnt_q   <= SR_EXIT_LOAD;
                        nop_cnt_q   <= 2'h0;
                    end
                end
                `SDMB_PWR_SUSPEND: begin
                    // Frozen burst resumes; next command taken next edge
                    if (I_CKE)
                        O_PWR_STATE <= `SDMB_PWR_NORMAL;
                end
                default: O_PWR_STATE <= `SDMB_PWR_NORMAL;
            endcase
        end
    end

    // Read data stream: newest read owns output one latency after registration
    always @(posedge I_CLK) begin
        if (I_RESET) begin
            rd_pipe_q       <= {RL{1'b0}};
            rd_bank_pipe_q  <= {2*RL{1'b0}};
            O_RD_DATA_VALID <= 1'b0;
            O_RD_DATA_BANK  <= 2'h0;
            O_WR_DATA_TAKE  <= 1'b0;
            O_CMD_ACCEPT    <= 1'b0;
            O_ILLEGAL       <= 1'b0;
            O_BANK_STATE    <= {3*NBANK{1'b0}};
        end else if (I_CE) begin
            rd_pipe_q      <= {rd_pipe_q[RL-2:0], burst_on_q && cur_rd_q};
            rd_bank_pipe_q <= {rd_bank_pipe_q[2*RL-3:0], cur_bank_q};
            O_RD_DATA_VALID <= rd_pipe_q[RL-2];
            O_RD_DATA_BANK  <= rd_bank_pipe_q[2*RL-3:2*RL-4];
            // Write word taken with the WRITE itself and through its burst; an
            // interrupting READ or terminate drops its own edge, so the last word is the one before
            O_WR_DATA_TAKE <= (cmd_live && cmd == `SDMB_CMD_WR) ||
                              (burst_on_q && !cur_rd_q && burst_cnt_q != 8'h01 &&
                               O_PWR_STATE != `SDMB_PWR_SUSPEND &&
                               !(cmd_live && (cmd == `SDMB_CMD_RD || cmd == `SDMB_CMD_BST)));
            O_CMD_ACCEPT   <= cmd_live && cmd_ok && cmd != `SDMB_CMD_NOP;
            O_ILLEGAL      <= cmd_live && !cmd_ok;
            O_BANK_STATE   <= {bank_st[3], bank_st[2], bank_st[1], bank_st[0]};
        end
    end

endmodule // sdmb_core
`default_nettype wire

// [design/sdmb_defs.vh]
// Purpose: Shared constants for the multibank command and clock-enable tracker
// Assumes: 200 MHz clock, 5 ns period
// Notes:   Times are in ns; cycle counts derive from them
`ifndef SDMB_DEFS_VH
`define SDMB_DEFS_VH

`define SDMB_CLK_PERIOD_NS   5
// Command codes {ras_n, cas_n, we_n}
`define SDMB_CMD_NOP         3'h7
`define SDMB_CMD_ACT         3'h3
`define SDMB_CMD_RD          3'h5
`define SDMB_CMD_WR          3'h4
`define SDMB_CMD_BST         3'h6
`define SDMB_CMD_PRE         3'h2
`define SDMB_CMD_REF         3'h1
`define SDMB_CMD_LMR         3'h0
// Bank states
`define SDMB_ST_IDLE         3'h0
`define SDMB_ST_ACTIVATING   3'h1
`define SDMB_ST_ACTIVE       3'h2
`define SDMB_ST_READ         3'h3
`define SDMB_ST_WRITE        3'h4
`define SDMB_ST_PRECHARGING  3'h5
`define SDMB_ST_WR_RECOVER   3'h6
// Device power states
`define SDMB_PWR_NORMAL      2'h0
`define SDMB_PWR_POWERDOWN   2'h1
`define SDMB_PWR_SELFREF     2'h2
`define SDMB_PWR_SUSPEND     2'h3
// Timing in ns
`define SDMB_T_PRECHARGE_NS  20
`define SDMB_T_ACT_COL_NS    20
`define SDMB_T_WR_RECOVER_NS 15
`define SDMB_T_SR_EXIT_NS    70
// Timing in cycles, least times rounded up
`define SDMB_CYC(ns) (((ns) + `SDMB_CLK_PERIOD_NS - 1) / `SDMB_CLK_PERIOD_NS)
`define SDMB_PRECHARGE_CYC   `SDMB_CYC(`SDMB_T_PRECHARGE_NS)
`define SDMB_ACT_COL_CYC     `SDMB_CYC(`SDMB_T_ACT_COL_NS)
`define SDMB_WR_RECOVER_CYC  `SDMB_CYC(`SDMB_T_WR_RECOVER_NS)
`define SDMB_SR_EXIT_CYC     `SDMB_CYC(`SDMB_T_SR_EXIT_NS)
`define SDMB_READ_LATENCY    3
`define SDMB_BURST_LEN       4
`define SDMB_SR_MIN_NOPS     2

`endif

// [sim/sdmb_core_asserts.sv]
// Purpose: Concurrent checks on the command tracker outputs
// Assumes: ACCEPT lags a command by one edge, bank state by two
// Notes:   Entry checks skip an edge right after an accepted command
`include "sdmb_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module sdmb_core_asserts #(
    parameter NBANK = 4, // Banks
    parameter RL    = 3, // Read latency
    parameter BL    = 4  // Burst length
) (
    input wire logic               I_CLK,           // Clock
    input wire logic               I_RESET,         // Reset
    input wire logic               I_CE,            // Logic enable
    input wire logic               I_CKE,           // Clock enable
    input wire logic               I_CS_N,          // Select
    input wire logic               I_RAS_N,         // Row strobe
    input wire logic               I_CAS_N,         // Column strobe
    input wire logic               I_WE_N,          // Write enable
    input wire logic [1:0]         I_BA,            // Bank
    input wire logic [3*NBANK-1:0] O_BANK_STATE,    // Bank states
    input wire logic [1:0]         O_PWR_STATE,     // Power state
    input wire logic               O_RD_DATA_VALID, // Read word
    input wire logic [1:0]         O_RD_DATA_BANK,  // Stream owner
    input wire logic               O_CMD_ACCEPT     // Accepted
);
    localparam int RDLY = RL; // ACCEPT lags one edge, and so does the stream
    // Decoded pins; all-idle test avoids edges where a command is still in flight
    wire logic [2:0] cmd = {I_RAS_N, I_CAS_N, I_WE_N};
    wire logic       nop = I_CS_N || cmd == `SDMB_CMD_NOP;
    wire logic       idle = I_CE && O_PWR_STATE == `SDMB_PWR_NORMAL && O_BANK_STATE == '0 && !O_CMD_ACCEPT;
    logic [2:0]      cmd_q;
    logic [1:0]      ba_q, ba_qq;
    // Command and bank of earlier edges, paired with the lagging outputs
    always @(posedge I_CLK) begin
        cmd_q <= cmd;
        ba_q  <= I_BA;
        ba_qq <= ba_q;
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    property p_inhibit; I_CS_N && I_CE |=> !O_CMD_ACCEPT; endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit took effect");
    property p_nop; !I_CS_N && cmd == `SDMB_CMD_NOP |=> !O_CMD_ACCEPT; endproperty
    a_nop: assert property (p_nop) else $error("nop took effect");
    property p_act; O_CMD_ACCEPT && cmd_q == `SDMB_CMD_ACT |=> O_BANK_STATE[3*ba_qq +: 3] == `SDMB_ST_ACTIVATING;
    endproperty
    a_act: assert property (p_act) else $error("activate not tracked");
    property p_rdlat; O_CMD_ACCEPT && cmd_q == `SDMB_CMD_RD
        |-> ##RDLY O_RD_DATA_VALID && O_RD_DATA_BANK == $past(ba_q, RDLY); endproperty
    a_rdlat: assert property (p_rdlat) else $error("read stream late or wrong bank");
    property p_hold; I_CE && O_PWR_STATE != `SDMB_PWR_NORMAL && !I_CKE && !$past(I_CKE) |=> $stable(O_PWR_STATE);
    endproperty
    a_hold: assert property (p_hold) else $error("low power state left with enable low");
    property p_pdx; I_CE && O_PWR_STATE == `SDMB_PWR_POWERDOWN && I_CKE && !$past(I_CKE) && nop
        |-> ##[1:2] O_PWR_STATE == `SDMB_PWR_NORMAL && O_BANK_STATE == '0; endproperty
    a_pdx: assert property (p_pdx) else $error("power-down exit slow");
    property p_pde; idle && !I_CKE && $past(I_CKE) && nop |-> ##[1:2] O_PWR_STATE == `SDMB_PWR_POWERDOWN;
    endproperty
    a_pde: assert property (p_pde) else $error("power-down not entered");
    property p_sre; idle && !I_CKE && $past(I_CKE) && !I_CS_N && cmd == `SDMB_CMD_REF
        |-> ##[1:2] O_PWR_STATE == `SDMB_PWR_SELFREF; endproperty
    a_sre: assert property (p_sre) else $error("self refresh not entered");
    property p_srx; I_CE && O_PWR_STATE == `SDMB_PWR_SELFREF && I_CKE && !$past(I_CKE) |=> !O_CMD_ACCEPT [*8];
    endproperty
    a_srx: assert property (p_srx) else $error("command taken in exit period");
    property p_csx; I_CE && O_PWR_STATE == `SDMB_PWR_SUSPEND && I_CKE && !$past(I_CKE)
        |-> ##[1:2] O_PWR_STATE == `SDMB_PWR_NORMAL; endproperty
    a_csx: assert property (p_csx) else $error("suspend exit slow");
    c_act: cover property (O_CMD_ACCEPT && cmd_q == `SDMB_CMD_ACT);
    c_pd: cover property (O_PWR_STATE == `SDMB_PWR_POWERDOWN);
    c_sr: cover property (O_PWR_STATE == `SDMB_PWR_SELFREF);
endmodule // sdmb_core_asserts
`default_nettype wire

// [sim/sdmb_ctrl_model.sv]
// Purpose: Controller model driving the command pins
// Assumes: Pins change only on the falling clock edge
// Notes:   Bank bits flip on NOP so stale values help nothing
`include "sdmb_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module sdmb_ctrl_model (
    input  wire logic       clk,  // Clock
    output var  logic       cke,  // Clock enable
    output var  logic       cs_n, // Select
    output var  logic [2:0] cmd,  // Strobes
    output var  logic [1:0] ba,   // Bank
    output var  logic       ap    // Auto precharge
);
    // Deselected, enable high, from time zero
    initial begin
        cke  = 1'h1;
        cs_n = 1'h1;
        cmd  = `SDMB_CMD_NOP;
        ba   = 2'h0;
        ap   = 1'h0;
    end
    // One command per edge, held from falling edge through the next rise
    task automatic put(input logic s, input logic [2:0] c, input logic [1:0] b, input logic a, input logic k);
        @(negedge clk);
        cke  = k;
        cs_n = s;
        cmd  = c;
        ba   = (c == `SDMB_CMD_NOP) ? ~ba : b;
        ap   = (c == `SDMB_CMD_NOP) ? ~ap : a;
    endtask
    // Gaps are filled with NOPs only
    task automatic nops(input int n, input logic k);
        repeat (n) put(1'h0, `SDMB_CMD_NOP, 2'h0, 1'h0, k);
    endtask
endmodule // sdmb_ctrl_model
`default_nettype wire

// [sim/tb_sdmb_core.sv]
// Purpose: Directed scenarios for the four-bank command tracker
// Assumes: Model drives pins on the falling edge; checks follow it
// Notes:   Bank state shows two edges after its cause, ACCEPT one
`include "sdmb_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_sdmb_core;
    logic        clk, rst, ce, cke, cs_n, ap, rvalid, wtake, acc, ill;
    logic [2:0]  cmd;
    logic [1:0]  ba, pwr, rbank;
    logic [11:0] bst;
    int          failures, checks;

    sdmb_ctrl_model u_sdmb_ctrl_model (.clk(clk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba), .ap(ap));
    sdmb_core u_sdmb_core (.I_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_CKE(cke), .I_CS_N(cs_n),
        .I_RAS_N(cmd[2]), .I_CAS_N(cmd[1]), .I_WE_N(cmd[0]), .I_BA(ba), .I_AP(ap), .O_BANK_STATE(bst),
        .O_PWR_STATE(pwr), .O_RD_DATA_VALID(rvalid), .O_RD_DATA_BANK(rbank), .O_WR_DATA_TAKE(wtake),
        .O_CMD_ACCEPT(acc), .O_ILLEGAL(ill));

    // 200 MHz clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    task automatic results;
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [2:0] c, input logic [1:0] b, input logic a, input logic k);
        u_sdmb_ctrl_model.put(1'h0, c, b, a, k);
    endtask
    task automatic nop(input int n, input logic k);
        u_sdmb_ctrl_model.nops(n, k);
    endtask
    function automatic logic [2:0] st(input logic [1:0] b);
        return bst[3*b +: 3];
    endfunction
    // Bounded wait for a bank state; running out ends the run
    task automatic wait_st(input logic [1:0] b, input logic [2:0] s);
        for (int i = 0; i < 40 && st(b) !== s; i++)
            nop(1, 1'h1);
        chk(st(b), s);
        if (st(b) !== s)
            results;
    endtask
    // Inhibit and NOP change nothing; ACTIVE opens banks back to back
    task automatic t_decode;
        u_sdmb_ctrl_model.put(1'h1, `SDMB_CMD_ACT, 2'h0, 1'h0, 1'h1);
        nop(1, 1'h1);
        chk(acc, 1'h0);
        nop(1, 1'h1);
        chk({acc, st(0)}, 4'h0);
        put(`SDMB_CMD_ACT, 2'h0, 1'h0, 1'h1);
        nop(1, 1'h1);
        chk(acc, 1'h1);
        nop(1, 1'h1);
        chk(st(0), `SDMB_ST_ACTIVATING);
        for (int b = 1; b < 4; b++)
            put(`SDMB_CMD_ACT, b[1:0], 1'h0, 1'h1);
        for (int b = 0; b < 4; b++)
            wait_st(b[1:0], `SDMB_ST_ACTIVE);
    endtask
    // Read with auto precharge cut by a read elsewhere, precharge in between
    task automatic t_read;
        put(`SDMB_CMD_RD, 2'h0, 1'h1, 1'h1);
        put(`SDMB_CMD_PRE, 2'h3, 1'h0, 1'h1);
        put(`SDMB_CMD_RD, 2'h1, 1'h0, 1'h1);
        nop(1, 1'h1);
        chk({st(0), st(3), rvalid, rbank}, {`SDMB_ST_READ, `SDMB_ST_PRECHARGING, 3'h0});
        nop(1, 1'h1);
        chk({st(0), st(1), rvalid, rbank}, {`SDMB_ST_PRECHARGING, `SDMB_ST_READ, 3'h4});
        nop(1, 1'h1);
        chk({rvalid, rbank}, 3'h4);
        nop(1, 1'h1);
        chk({rvalid, rbank}, 3'h5);
        wait_st(2'h0, `SDMB_ST_IDLE);
        wait_st(2'h1, `SDMB_ST_ACTIVE);
    endtask
    // Write with auto precharge cut after one word by a read elsewhere
    task automatic t_write;
        put(`SDMB_CMD_WR, 2'h2, 1'h1, 1'h1);
        put(`SDMB_CMD_RD, 2'h1, 1'h0, 1'h1);
        chk(wtake, 1'h1);
        nop(1, 1'h1);
        chk(wtake, 1'h0);
        nop(1, 1'h1);
        chk(st(2), `SDMB_ST_WR_RECOVER);
        wait_st(2'h2, `SDMB_ST_IDLE);
    endtask
    // Refresh with a bank open is refused, then all banks are closed
    task automatic t_refresh;
        put(`SDMB_CMD_REF, 2'h0, 1'h0, 1'h1);
        nop(1, 1'h1);
        chk({ill, acc}, 2'h2);
        put(`SDMB_CMD_PRE, 2'h0, 1'h1, 1'h1);
        for (int b = 0; b < 4; b++)
            wait_st(b[1:0], `SDMB_ST_IDLE);
    endtask
    // Power-down entry, ignored command, exit with NOP
    task automatic t_powerdown;
        nop(1, 1'h0);
        nop(2, 1'h0);
        chk(pwr, `SDMB_PWR_POWERDOWN);
        put(`SDMB_CMD_ACT, 2'h1, 1'h0, 1'h0);
        nop(1, 1'h0);
        chk({pwr, acc}, 3'h2);
        ce = 1'h0;
        nop(1, 1'h1);
        nop(1, 1'h0);
        chk(pwr, `SDMB_PWR_POWERDOWN);
        ce = 1'h1;
        nop(1, 1'h1);
        nop(1, 1'h1);
        chk({pwr, bst}, 14'h0);
    endtask
    // Self refresh; a command inside the exit period is dropped
    task automatic t_selfref;
        put(`SDMB_CMD_REF, 2'h0, 1'h0, 1'h0);
        nop(3, 1'h0);
        chk(pwr, `SDMB_PWR_SELFREF);
        nop(1, 1'h1);
        put(`SDMB_CMD_ACT, 2'h2, 1'h0, 1'h1);
        nop(1, 1'h1);
        chk(acc, 1'h0);
        nop(`SDMB_SR_EXIT_CYC, 1'h1);
        put(`SDMB_CMD_ACT, 2'h2, 1'h0, 1'h1);
        nop(1, 1'h1);
        chk(acc, 1'h1);
    endtask
    // Clock suspend inside a write burst, next command right after exit
    task automatic t_suspend;
        wait_st(2'h2, `SDMB_ST_ACTIVE);
        put(`SDMB_CMD_WR, 2'h2, 1'h0, 1'h1);
        nop(1, 1'h0);
        nop(2, 1'h0);
        chk(pwr, `SDMB_PWR_SUSPEND);
        nop(1, 1'h1);
        put(`SDMB_CMD_PRE, 2'h2, 1'h0, 1'h1);
        nop(1, 1'h1);
        chk(acc, 1'h1);
    endtask
    // Reset for two cycles, then the scenarios in order
    initial begin
        failures = 0;
        checks   = 0;
        ce       = 1'h1;
        rst      = 1'h1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        t_decode;
        t_read;
        t_write;
        t_refresh;
        t_powerdown;
        t_selfref;
        t_suspend;
        results;
    end
endmodule // tb_sdmb_core

bind sdmb_core sdmb_core_asserts #(.NBANK(NBANK), .RL(RL), .BL(BL)) u_sdmb_core_asserts (.I_CLK(I_CLK),
    .I_RESET(I_RESET), .I_CE(I_CE), .I_CKE(I_CKE), .I_CS_N(I_CS_N), .I_RAS_N(I_RAS_N), .I_CAS_N(I_CAS_N),
    .I_WE_N(I_WE_N), .I_BA(I_BA), .O_BANK_STATE(O_BANK_STATE), .O_PWR_STATE(O_PWR_STATE),
    .O_RD_DATA_VALID(O_RD_DATA_VALID), .O_RD_DATA_BANK(O_RD_DATA_BANK), .O_CMD_ACCEPT(O_CMD_ACCEPT));
`default_nettype wire
